// file: hw/tw8_timer.sv
/*
  8-bit timer/counter with two compare channels and waveform outputs,
  reached as an apb slave with zero wait states.
  assumes pclk is the i/o clock (200 MHz) and that ext_count_pin and the
  interrupt acknowledges come from outside and are synchronised here.
*/
// Overview of operation
// - nonzero b action drives pin b when its direction bit is set
// - non-pwm actions: off, toggle, clear, set
// - fast pwm b: non-inverting, inverting, 01 reserved
// - fast pwm compare-equals-top acts at bottom
// - phase pwm: non-inverting clears up, sets down; inverting the reverse
// - phase pwm compare-equals-top acts at top
// - unused control bits read zero
// - mode split across both control registers
// - mode table selects count top
// - compare buffer update point per mode
// - overflow flag point per mode
// - force strobes only in non-pwm modes
// - force applies action immediately
// - force: no flag, no clear, reads zero
// - clock select: stop, prescaler taps
// - external pin edges clock counter
// - counter rw, write blocks next match
// - compare a compared continuously
// - flags clear by ack or write-one
// - interrupt needs enable and global enable
`timescale 1ns/1ps
module tw8_timer
  import tw8_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_count_pin,
  input  wire logic        ack_overflow,
  input  wire logic        ack_match_a,
  input  wire logic        ack_match_b,
  output logic             irq_overflow,
  output logic             irq_match_a,
  output logic             irq_match_b,
  output logic             wave_out_a,
  output logic             wave_out_a_oe,
  output logic             wave_out_b,
  output logic             wave_out_b_oe
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [1:0] out_a_action;     // channel a output action
    logic [1:0] out_b_action;     // channel b output action
    logic [1:0] wave_mode_low;    // low mode bits
    logic       wave_mode_high;   // high mode bit
    logic [2:0] clock_source_select;
    logic [7:0] counter_value;
    logic [7:0] cmp_a_buf;        // software copy of compare a
    logic [7:0] cmp_b_buf;
    logic [7:0] cmp_a_act;        // copy the comparator uses
    logic [7:0] cmp_b_act;
    logic [2:0] irq_en;
    logic       gie;
    logic [2:0] flags;            // overflow, match a, match b
    logic [1:0] pin_dir;
    logic       wave_a;
    logic       wave_b;
    logic       count_down;       // phase modes only
    logic       block_match;      // set by counter write
    logic [9:0] presc;
    logic       ext_s1;           // synchroniser stage one
    logic       ext_s2;
    logic       ext_prev;
    logic [2:0] ack_s1;
    logic [2:0] ack_s2;
    logic [2:0] ack_prev;
  } tw8_state_s;

  tw8_state_s s;       // registered state
  tw8_state_s next_s;  // next state

  // ************************************************************
  // output law for one channel
  // ************************************************************
  // shared by both channels; only channel a may toggle in pwm modes
  function automatic logic wave_calc(input logic [1:0] act, input logic pwm_tgl,
                                     input logic fast, input logic phase,
                                     input logic match, input logic special,
                                     input logic wrap, input logic at_top,
                                     input logic down, input logic cur);
    logic v;
    v = cur;
    if (!fast && !phase) begin
      if (match) begin
        unique case (act)
          2'h1:    v = ~cur;   // toggle
          2'h2:    v = 1'b0;   // clear
          2'h3:    v = 1'b1;   // set
          default: v = cur;
        endcase
      end
    end else if (act == 2'h1) begin
      // reserved for b, toggle for a when high mode bit set
      if (pwm_tgl && match) begin
        v = ~cur;
      end
    end else if (act[1]) begin
      if (fast) begin
        if (wrap) begin
          v = ~act[0];               // bottom action
        end else if (match && !special) begin
          v = act[0];                // match action
        end
      end else begin
        if (special) begin
          if (at_top) begin
            v = ~act[0];             // acts at top instead
          end
        end else if (match) begin
          v = down ? ~act[0] : act[0];
        end
      end
    end
    return v;
  endfunction

  // ************************************************************
  // decode and timer clock
  // ************************************************************
  logic [2:0] wave_mode_field;  // full mode
  logic       is_phase;         // phase-correct modes
  logic       is_fast;          // fast pwm modes
  logic       non_pwm;          // normal, clear-on-match, reserved
  logic [7:0] top;              // current top value
  logic       tick;             // timer clock enable
  logic       match_a;          // compare events on tick
  logic       match_b;
  logic       wrap;             // single-slope top reached
  logic       at_top;           // phase turn at top
  logic       at_bot;           // phase turn at bottom
  logic       ovf_set;
  logic       wr_en;            // apb write takes effect
  logic       rd_en;
  logic [9:0] idx;              // register index
  logic       hit;              // mapped address

  assign wave_mode_field = {s.wave_mode_high, s.wave_mode_low};
  assign is_phase = (wave_mode_field == MODE_PC_FF) || (wave_mode_field == MODE_PC_CMPA);
  assign is_fast  = (wave_mode_field == MODE_FAST_FF) || (wave_mode_field == MODE_FAST_CMP);
  assign non_pwm  = !is_phase && !is_fast;
  // compare a as top in clear-on-match, phase and fast variants
  assign top = (wave_mode_field == MODE_CLR_CMP || wave_mode_field == MODE_PC_CMPA ||
                wave_mode_field == MODE_FAST_CMP) ? s.cmp_a_act : CNT_MAX;

  // prescaler taps and synchronised external edges
  always_comb begin
    unique case (s.clock_source_select)
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (s.presc & TAP_DIV8) == TAP_DIV8;
      CS_DIV64:    tick = (s.presc & TAP_DIV64) == TAP_DIV64;
      CS_DIV256:   tick = (s.presc & TAP_DIV256) == TAP_DIV256;
      CS_DIV1024:  tick = s.presc == TAP_DIV1024;
      CS_EXT_FALL: tick = s.ext_prev && !s.ext_s2;
      CS_EXT_RISE: tick = !s.ext_prev && s.ext_s2;
    endcase
  end

  // a counter write removes matches until the next tick
  assign match_a = tick && !s.block_match && (s.counter_value == s.cmp_a_act);
  assign match_b = tick && !s.block_match && (s.counter_value == s.cmp_b_act);
  assign wrap   = tick && !is_phase && (s.counter_value == top);
  assign at_top = tick && is_phase && !s.count_down && (s.counter_value == top);
  assign at_bot = tick && is_phase && s.count_down && (s.counter_value == CNT_BOTTOM);

  // overflow point per mode
  always_comb begin
    if (is_phase) begin
      ovf_set = at_bot;
    end else if (wave_mode_field == MODE_FAST_CMP) begin
      ovf_set = wrap;
    end else begin
      ovf_set = tick && (s.counter_value == CNT_MAX);
    end
  end

  // ************************************************************
  // apb slave: zero wait states, error on unmapped index
  // ************************************************************
  assign idx    = paddr[11:2];
  assign hit    = (idx >= IDX_CTRL_A) && (idx <= IDX_PIN_DIR);
  assign wr_en  = psel && penable && pwrite && hit;
  assign rd_en  = psel && !pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // read mux; reserved and strobe bits read zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (idx)
        IDX_CTRL_A:   prdata[7:0] = {s.out_a_action, s.out_b_action, 2'b00, s.wave_mode_low};
        IDX_CTRL_B:   prdata[7:0] = {4'h0, s.wave_mode_high, s.clock_source_select};
        IDX_COUNT:    prdata[7:0] = s.counter_value;
        IDX_CMP_A:    prdata[7:0] = s.cmp_a_buf;
        IDX_CMP_B:    prdata[7:0] = s.cmp_b_buf;
        IDX_IRQ_MASK: prdata[7:0] = {s.gie, 4'h0, s.irq_en};
        IDX_FLAGS:    prdata[7:0] = {5'h00, s.flags};
        IDX_PIN_DIR:  prdata[7:0] = {6'h00, s.pin_dir};
        default:      prdata = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [2:0] set_f;   // hardware flag sets
    logic [2:0] clr_f;   // acknowledge and write-one clears
    logic       frc;     // force strobe accepted
    set_f = 3'h0;
    clr_f = 3'h0;
    frc = 1'b0;
    next_s = s;
    // input synchronisers; stage one feeds stage two only
    next_s.ext_s1 = ext_count_pin;
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_prev = s.ext_s2;
    next_s.ack_s1 = {ack_match_b, ack_match_a, ack_overflow};
    next_s.ack_s2 = s.ack_s1;
    next_s.ack_prev = s.ack_s2;
    next_s.presc = s.presc + 10'h001;

    // counting sequence
    if (tick) begin
      next_s.block_match = 1'b0;
      if (is_phase) begin
        // up to top, turn, down to bottom, turn
        if (at_top) begin
          next_s.count_down = 1'b1;
          next_s.counter_value = s.counter_value - 8'h01;
        end else if (at_bot) begin
          next_s.count_down = 1'b0;
          next_s.counter_value = s.counter_value + 8'h01;
        end else if (s.count_down) begin
          next_s.counter_value = s.counter_value - 8'h01;
        end else begin
          next_s.counter_value = s.counter_value + 8'h01;
        end
      end else begin
        next_s.count_down = 1'b0;
        next_s.counter_value = wrap ? CNT_BOTTOM : s.counter_value + 8'h01;
      end
    end

    // compare buffer update point
    if (non_pwm) begin
      next_s.cmp_a_act = s.cmp_a_buf;
      next_s.cmp_b_act = s.cmp_b_buf;
    end else if ((is_fast && wrap) || at_top) begin
      next_s.cmp_a_act = s.cmp_a_buf;
      next_s.cmp_b_act = s.cmp_b_buf;
    end

    // waveforms from compare events
    next_s.wave_a = wave_calc(s.out_a_action, s.wave_mode_high, is_fast, is_phase, match_a,
                              (s.cmp_a_act == top) && s.out_a_action[1], wrap, at_top,
                              s.count_down, s.wave_a);
    next_s.wave_b = wave_calc(s.out_b_action, 1'b0, is_fast, is_phase, match_b,
                              (s.cmp_b_act == top) && s.out_b_action[1], wrap, at_top,
                              s.count_down, s.wave_b);
    set_f = {match_b, match_a, ovf_set};

    // register writes
    if (wr_en) begin
      unique case (idx)
        IDX_CTRL_A: begin
          next_s.out_a_action = pwdata[ACT_A_HI:ACT_A_LO];
          next_s.out_b_action = pwdata[ACT_B_HI:ACT_B_LO];
          next_s.wave_mode_low = pwdata[WGM_LO_HI:0];
        end
        IDX_CTRL_B: begin
          next_s.wave_mode_high = pwdata[WGM_HI];
          next_s.clock_source_select = pwdata[CS_HI:0];
          frc = non_pwm; // strobes ignored in pwm
          // forced match: current action, no flag, no clear
          if (frc && pwdata[FORCE_A]) begin
            next_s.wave_a = wave_calc(s.out_a_action, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0,
                                      1'b0, 1'b0, 1'b0, s.wave_a);
          end
          if (frc && pwdata[FORCE_B]) begin
            next_s.wave_b = wave_calc(s.out_b_action, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0,
                                      1'b0, 1'b0, 1'b0, s.wave_b);
          end
        end
        IDX_COUNT: begin
          // write beats the tick and blocks the next match
          next_s.counter_value = pwdata[7:0];
          next_s.block_match = 1'b1;
        end
        IDX_CMP_A:    next_s.cmp_a_buf = pwdata[7:0];
        IDX_CMP_B:    next_s.cmp_b_buf = pwdata[7:0];
        IDX_IRQ_MASK: begin
          next_s.irq_en = pwdata[MB_BIT:OVF_BIT];
          next_s.gie = pwdata[GIE_BIT];
        end
        IDX_FLAGS:    clr_f = pwdata[MB_BIT:OVF_BIT];
        IDX_PIN_DIR:  next_s.pin_dir = pwdata[DIR_B:DIR_A];
        default:      next_s.pin_dir = s.pin_dir;
      endcase
    end

    // sticky flags: acknowledge edge or write one clears, set wins
    clr_f = clr_f | (s.ack_s2 & ~s.ack_prev);
    next_s.flags = (s.flags & ~clr_f) | set_f;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // pins driven only with direction set by software
  assign wave_out_a = s.wave_a;
  assign wave_out_b = s.wave_b;
  assign wave_out_a_oe = (s.out_a_action != 2'h0) && s.pin_dir[DIR_A];
  assign wave_out_b_oe = (s.out_b_action != 2'h0) && s.pin_dir[DIR_B];
  // request needs flag, own enable and global enable
  assign irq_overflow = s.flags[OVF_BIT] && s.irq_en[OVF_BIT] && s.gie;
  assign irq_match_a  = s.flags[MA_BIT] && s.irq_en[MA_BIT] && s.gie;
  assign irq_match_b  = s.flags[MB_BIT] && s.irq_en[MB_BIT] && s.gie;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_b_release: assert property (s.out_b_action == 2'h0 |-> !wave_out_b_oe)
    else $error("pin b driven with action off");
  a_rsvd_read_zero: assert property (rd_en && idx == IDX_CTRL_B |-> prdata[7:4] == 4'h0)
    else $error("control b reserved bits not zero");
  a_force_no_flag: assert property (wr_en && idx == IDX_CTRL_B && !tick && pwdata[FORCE_B]
    && s.ack_s2 == s.ack_prev |=> s.flags == $past(s.flags))
    else $error("forced match changed a flag");
  a_force_toggle: assert property (wr_en && idx == IDX_CTRL_B && non_pwm && pwdata[FORCE_B]
    && s.out_b_action == 2'h1 |=> s.wave_b != $past(s.wave_b))
    else $error("forced toggle on b missing");
  a_stop_holds: assert property (s.clock_source_select == CS_STOP && !(wr_en && idx == IDX_COUNT)
    |=> $stable(s.counter_value))
    else $error("stopped counter moved");
  a_count_write: assert property (wr_en && idx == IDX_COUNT |=> s.counter_value == $past(pwdata[7:0])
    && !match_a)
    else $error("counter write lost or match not blocked");
  a_match_clear: assert property (wave_mode_field == MODE_CLR_CMP && match_a && !wr_en
    |=> s.counter_value == CNT_BOTTOM)
    else $error("clear-on-match mode did not clear on match a");
  a_ovf_normal: assert property (wave_mode_field == MODE_NORMAL && tick && s.counter_value == CNT_MAX
    |=> s.flags[OVF_BIT])
    else $error("overflow flag missing at max");
  a_irq_gate: assert property (irq_match_b |-> s.gie && s.irq_en[MB_BIT] && s.flags[MB_BIT])
    else $error("match b request without enables");
  a_flag_wclr: assert property (wr_en && idx == IDX_FLAGS && pwdata[MA_BIT] && !match_a
    |=> !s.flags[MA_BIT])
    else $error("write one did not clear match a flag");
endmodule

// file: hw/tw8_pkg.sv
/*
  constants for the 8-bit waveform timer: register indices, field positions,
  mode and clock-select codes, prescaler taps and reset values.
  assumes an apb slave with 32-bit data and one aligned word per register.
*/
package tw8_pkg;
  // ************************************************************
  // register indices (byte address = 4 * index)
  // ************************************************************
  localparam logic [9:0] IDX_CTRL_A   = 10'h024;  // output actions and low mode bits
  localparam logic [9:0] IDX_CTRL_B   = 10'h025;  // force strobes, high mode bit, clock select
  localparam logic [9:0] IDX_COUNT    = 10'h026;  // counter
  localparam logic [9:0] IDX_CMP_A    = 10'h027;  // compare a
  localparam logic [9:0] IDX_CMP_B    = 10'h028;  // compare b
  localparam logic [9:0] IDX_IRQ_MASK = 10'h029;  // enables and global enable
  localparam logic [9:0] IDX_FLAGS    = 10'h02a;  // sticky flags, write one to clear
  localparam logic [9:0] IDX_PIN_DIR  = 10'h02b;  // pin direction bits

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ACT_A_HI = 7;   // control a
  localparam int ACT_A_LO = 6;
  localparam int ACT_B_HI = 5;
  localparam int ACT_B_LO = 4;
  localparam int WGM_LO_HI = 1;
  localparam int FORCE_A  = 7;   // control b
  localparam int FORCE_B  = 6;
  localparam int WGM_HI   = 3;
  localparam int CS_HI    = 2;
  localparam int GIE_BIT  = 7;   // mask register
  localparam int OVF_BIT  = 0;   // flags / mask
  localparam int MA_BIT   = 1;
  localparam int MB_BIT   = 2;
  localparam int DIR_A    = 0;   // pin direction
  localparam int DIR_B    = 1;

  // ************************************************************
  // modes, clock selects, counter limits
  // ************************************************************
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_PC_FF    = 3'h1;
  localparam logic [2:0] MODE_CLR_CMP  = 3'h2;
  localparam logic [2:0] MODE_FAST_FF  = 3'h3;
  localparam logic [2:0] MODE_PC_CMPA  = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;
  localparam logic [2:0] CS_STOP  = 3'h0;
  localparam logic [2:0] CS_DIV1  = 3'h1;
  localparam logic [2:0] CS_DIV8  = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] TAP_DIV8    = 10'h007;
  localparam logic [9:0] TAP_DIV64   = 10'h03f;
  localparam logic [9:0] TAP_DIV256  = 10'h0ff;
  localparam logic [9:0] TAP_DIV1024 = 10'h3ff;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] REG_RESET  = 8'h00;
endpackage

// file: verification/tw8_pin_model.sv
/*
  pin-side partner of the waveform timer: channel b pad with a pull-up and
  a source for the external count pin.
  assumes the bench calls pulse() from its own thread, between clock edges.
*/
`timescale 1ns/1ps
module tw8_pin_model (
  input  wire logic pclk,
  input  wire logic wave_out_b,
  input  wire logic wave_out_b_oe,
  output logic      pin_b,
  output logic      ext_count_pin
);
  // released pad floats to the pull-up, never to the last driven level
  assign pin_b = wave_out_b_oe ? wave_out_b : 1'b1;

  // count pin idles low until the bench asks for edges
  initial ext_count_pin = 1'b0;

  // each level lasts 8 cycles, well above the 3-cycle sync and edge delay
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (8) @(posedge pclk);
      ext_count_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      ext_count_pin <= 1'b0;
    end
    repeat (8) @(posedge pclk);
  endtask
endmodule

// file: verification/tb_timer8_waveform_control.sv
/*
  self-checking bench for the 8-bit waveform timer: apb tasks, one task per
  scenario. assumes a zero-wait apb slave and the pin model beside it.
*/
`timescale 1ns/1ps
module tb_timer8_waveform_control
  import tw8_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ext_count_pin, pin_b, ack_overflow, ack_match_a, ack_match_b;
  logic        irq_overflow, irq_match_a, irq_match_b;
  logic        wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
  int          fail_count, n_checks, cyc;

  tw8_timer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_count_pin, .ack_overflow, .ack_match_a, .ack_match_b, .irq_overflow,
    .irq_match_a, .irq_match_b, .wave_out_a, .wave_out_a_oe, .wave_out_b, .wave_out_b_oe);
  tw8_pin_model pins (.pclk, .wave_out_b, .wave_out_b_oe, .pin_b, .ext_count_pin);

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // hang guard: the run needs about 19k cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count = fail_count + 1;
      tally_and_finish();
    end
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // only the hang guard ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // reset values, reserved bits, strobes reading zero, unmapped word
  task automatic t_regs();
    rdchk(IDX_CTRL_B, 32'h0000_0000);
    rdchk(IDX_COUNT, 32'h0000_0000);
    wr(IDX_CTRL_A, 8'hff);
    rdchk(IDX_CTRL_A, 32'h0000_00f3);
    wr(IDX_CTRL_B, 8'hf8);
    rdchk(IDX_CTRL_B, 32'h0000_0008);
    wr(10'h03f, 8'h55);
    check(32'(err), 32'h0000_0001);
    rdchk(10'h03f, 32'h0000_0000);
  endtask

  // forced matches walk set, toggle, toggle and clear on channel b, clock stopped
  task automatic t_force();
    logic [7:0] acts;
    logic [3:0] exp;
    acts = 8'hd6;
    exp  = 4'ha;
    wr(IDX_PIN_DIR, 8'h02);
    for (int i = 3; i >= 0; i--) begin
      wr(IDX_CTRL_A, {2'b00, acts[2*i+:2], 4'h0});
      wr(IDX_CTRL_B, 8'h40);
      check(32'(pin_b), 32'(exp[i]));
      check(32'(wave_out_b_oe), 32'h0000_0001);
    end
    rdchk(IDX_FLAGS, 32'h0000_0000);
    wr(IDX_CTRL_A, 8'h33);
    wr(IDX_CTRL_B, 8'h40);
    check(32'(pin_b), 32'h0000_0000);
    wr(IDX_CTRL_A, 8'h00);
    check(32'(pin_b), 32'h0000_0001);
    // channel a: forced set lands, but pin a stays undriven without its direction bit
    wr(IDX_CTRL_A, 8'hc0);
    wr(IDX_CTRL_B, 8'h80);
    check(32'(wave_out_a), 32'h0000_0001);
    check(32'(wave_out_a_oe), 32'h0000_0000);
  endtask

  // clear-on-match with top 5: match flag, no overflow, mask, both clears
  task automatic t_ctc();
    // compare b parked above top 5 so only channel a can flag here
    wr(IDX_CMP_B, 8'h80);
    wr(IDX_CMP_A, 8'h05);
    wr(IDX_CTRL_A, 8'h02);
    wr(IDX_FLAGS, 8'h07);
    wr(IDX_IRQ_MASK, 8'h02);
    wr(IDX_CTRL_B, 8'h01);
    repeat (20) @(posedge pclk);
    wr(IDX_CTRL_B, 8'h00);
    rdchk(IDX_FLAGS, 32'h0000_0002);
    check(32'(irq_match_a), 32'h0000_0000);
    apb(1'b0, IDX_COUNT, 8'h00);
    check(32'(rd <= 32'h0000_0005), 32'h0000_0001);
    wr(IDX_IRQ_MASK, 8'h82);
    check(32'(irq_match_a), 32'h0000_0001);
    ack_match_a <= 1'b1;
    repeat (6) @(posedge pclk);
    ack_match_a <= 1'b0;
    rdchk(IDX_FLAGS, 32'h0000_0000);
    wr(IDX_CTRL_B, 8'h01);
    repeat (20) @(posedge pclk);
    wr(IDX_CTRL_B, 8'h00);
    wr(IDX_FLAGS, 8'h02);
    rdchk(IDX_FLAGS, 32'h0000_0000);
    wr(IDX_IRQ_MASK, 8'h00);
  endtask

  // counter write onto the compare value while running hides that match
  task automatic t_cntwr();
    wr(IDX_CTRL_A, 8'h00);
    wr(IDX_CMP_A, 8'h0a);
    wr(IDX_COUNT, 8'h64);
    wr(IDX_FLAGS, 8'h07);
    wr(IDX_CTRL_B, 8'h01);
    wr(IDX_COUNT, 8'h0a);
    rdchk(IDX_FLAGS, 32'h0000_0000);
    // the sweep passes compare b (0x80), max and compare a after the wrap
    repeat (300) @(posedge pclk);
    wr(IDX_CTRL_B, 8'h00);
    rdchk(IDX_FLAGS, 32'h0000_0007);
  endtask

  // each prescaler tap gives 8 or so ticks in 8 of its periods
  task automatic t_presc();
    int div [6];
    logic [31:0] last;
    div = '{1, 1, 8, 64, 256, 1024};
    for (int i = 1; i < 6; i++) begin
      wr(IDX_COUNT, 8'h00);
      wr(IDX_CTRL_B, 8'(i));
      repeat (8 * div[i]) @(posedge pclk);
      wr(IDX_CTRL_B, 8'h00);
      apb(1'b0, IDX_COUNT, 8'h00);
      check(32'(rd >= 32'h0000_0008 && rd <= 32'h0000_000b), 32'h0000_0001);
    end
    // a stopped counter keeps the value read last
    last = rd;
    repeat (20) @(posedge pclk);
    apb(1'b0, IDX_COUNT, 8'h00);
    check(rd, last);
  endtask

  // external pin: three rising then two falling edges
  task automatic t_ext();
    wr(IDX_COUNT, 8'h00);
    wr(IDX_CTRL_B, 8'h07);
    pins.pulse(3);
    wr(IDX_CTRL_B, 8'h06);
    pins.pulse(2);
    wr(IDX_CTRL_B, 8'h00);
    rdchk(IDX_COUNT, 32'h0000_0005);
  endtask

  // high time of pin b over one pwm period, per mode, action and compare
  task automatic t_pwm();
    logic [7:0] ca [8];
    logic [7:0] cb [8];
    logic [7:0] ra [8];
    logic [7:0] rb [8];
    int per [8];
    int lo [8];
    int hi [8];
    int h;
    ca = '{8'h23, 8'h33, 8'h23, 8'h21, 8'h31, 8'h21, 8'h23, 8'h21};
    cb = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h09, 8'h09};
    ra = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h3f};
    rb = '{8'h40, 8'h40, 8'hff, 8'h40, 8'h40, 8'hff, 8'h10, 8'h10};
    per = '{256, 256, 256, 510, 510, 510, 64, 126};
    lo = '{64, 190, 256, 126, 379, 510, 16, 31};
    hi = '{66, 192, 256, 131, 384, 510, 18, 35};
    for (int i = 0; i < 8; i++) begin
      wr(IDX_CTRL_B, 8'h00);
      wr(IDX_CTRL_A, 8'h00);
      // start from bottom so a short top is reached inside the warm-up
      wr(IDX_COUNT, 8'h00);
      wr(IDX_CMP_A, ra[i]);
      wr(IDX_CMP_B, rb[i]);
      wr(IDX_CTRL_A, ca[i]);
      wr(IDX_CTRL_B, cb[i]);
      repeat (2 * per[i]) @(posedge pclk);
      h = 0;
      repeat (per[i]) begin
        @(posedge pclk);
        h = h + int'(pin_b === 1'b1);
      end
      check(32'(h >= lo[i] && h <= hi[i]), 32'h0000_0001);
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ack_overflow = 1'b0;
    ack_match_a = 1'b0;
    ack_match_b = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_force();
    t_ctc();
    t_cntwr();
    t_presc();
    t_ext();
    t_pwm();
    tally_and_finish();
  end
endmodule
